// >>> include/ats_defs.svh
// Constants for the auto-reload timer and interrupt control block.
// Assumes a Wishbone master that reaches one byte register per word.
`ifndef ATS_DEFS_SVH
`define ATS_DEFS_SVH

// Register indices; byte address is four times the index
`define ATS_IDX_POWER 8'h87
`define ATS_IDX_CTRL 8'h88
`define ATS_IDX_GONE_MODE 8'h89
`define ATS_IDX_COUNT_LOW 8'h8A
`define ATS_IDX_RELOAD_LOW 8'h8B
`define ATS_IDX_COUNT_HIGH 8'h8C
`define ATS_IDX_RELOAD_HIGH 8'h8D
`define ATS_IDX_GONE_PORT_TWO 8'hA0
`define ATS_IDX_IRQ_ENABLE 8'hA8
`define ATS_IDX_GONE_PRIORITY 8'hB8

// timer_control fields
`define ATS_CTRL_GATE 7
`define ATS_CTRL_SRC 6
`define ATS_CTRL_OVF 5
`define ATS_CTRL_RUN 4
`define ATS_CTRL_P0 3
`define ATS_CTRL_E0 2
`define ATS_CTRL_P1 1
`define ATS_CTRL_E1 0

// Interrupt enable fields
`define ATS_IEN_ALL 7
`define ATS_IEN_X1 2
`define ATS_IEN_T 1
`define ATS_IEN_X0 0

// Power control fields
`define ATS_PWR_PD 1
`define ATS_PWR_IDL 0

`define ATS_RESET_BYTE 8'h00
`define ATS_COUNT_TOP 16'hFFFF

// Vector addresses
`define ATS_VEC_RESET 10'h000
`define ATS_VEC_X0 10'h003
`define ATS_VEC_T 10'h00B
`define ATS_VEC_X1 10'h013

// Oscillator periods per machine cycle, program memory size
`define ATS_MC_DIV 12
`define ATS_PROG_BYTES 1024

`endif

// >>> include/ats_pkg.sv
// Types shared by the timer block.
// Assumes ats_defs.svh is on the include path.
package ats_pkg;
    typedef enum logic [1:0] {
        ATS_SRC_NONE,
        ATS_SRC_IRQ0,
        ATS_SRC_TIMER,
        ATS_SRC_IRQ1
    } ats_src_type;
endpackage

// >>> rtl/ats_timer_ctl.sv
// Auto-reload 16-bit timer/counter with control register and interrupt resolver.
// Assumes a classic Wishbone master on clk_i and asynchronous pins.
//
// Behaviour
// - Power-down stops the machine-cycle clock; only reset leaves it.
// - Program memory is fixed at 1024 bytes with no external expansion.
// - Vectors: reset 000, first pin 003, timer 00B, second pin 013.
// - Count at one twelfth of the clock or from count input falling transitions.
// - Source select 1 counts falling pin transitions, 0 counts machine cycles.
// - Count advances only while run enable is set, otherwise holds.
// - Overflow reloads count from reload registers, which stay unchanged.
// - Overflow sets overflow flag; cleared on vectoring and reset.
// - Gating set: advance only while first pin high and run enabled.
// - Edge mode: falling edge on pin sets its pending flag.
// - Level mode: pending follows the low pin level.
// - Control bits: gate, source, overflow, run, p0, e0, p1, e1.
// - Fixed priority: first pin, then timer, then second pin.
// - Legacy mode, port two and priority slots are absent.
// - Reload registers sit in the old second timer count slots.
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`include "ats_defs.svh"

module ats_timer_ctl #(
    parameter int PROG_BYTES = `ATS_PROG_BYTES, // Program memory size
    parameter int MC_DIV = `ATS_MC_DIV // Clocks per machine cycle
) (
    input wire logic clk_i, // Oscillator clock, 10 MHz
    input wire logic rst_i, // Synchronous reset, high
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_we_i, // Write enable
    input wire logic [9:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic count_input_pin_i, // Count input pin
    input wire logic ext_irq_first_pin_i, // First interrupt pin, active low
    input wire logic ext_irq_second_pin_i, // Second interrupt pin, active low
    input wire logic irq_ack_i, // Core vectors to current request
    output logic irq_req_o, // Interrupt request
    output logic [9:0] irq_vector_o, // Vector of current request
    output ats_pkg::ats_src_type irq_src_o, // Source of current request
    output logic idle_o, // Idle mode
    output logic power_down_o // Power-down, oscillator stopped
);
    import ats_pkg::*;

    // Refused at elaboration, before any logic is built
    if (PROG_BYTES != `ATS_PROG_BYTES)
        $error("Program memory size is fixed");
    if (MC_DIV < 2 || MC_DIV > 255)
        $error("Machine cycle divider out of range");

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
        hit = (idx == want);
    endfunction

    // Pin synchronisers: bit 0 count, bit 1 first irq, bit 2 second irq
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic [1:0] irq_prev_q;
    logic count_smp_q;
    logic [7:0] div_q;
    logic [7:0] ctrl_q;
    logic [7:0] ien_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] reload_q;
    logic idle_q;
    logic pd_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic req_q;
    logic [9:0] vec_q;
    ats_src_type src_q;
    logic [7:0] ctrl_d;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_meta_q <= 3'h7;
            pin_sync_q <= 3'h7;
        end
        else
        begin
            pin_meta_q <= {ext_irq_second_pin_i, ext_irq_first_pin_i, count_input_pin_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    wire count_pin = pin_sync_q[0];
    wire irq0_pin = pin_sync_q[1];
    wire irq1_pin = pin_sync_q[2];

    // Machine-cycle enable; frozen in power-down since the oscillator is off
    wire tick = (div_q == 8'(MC_DIV - 1)) && !pd_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || tick)
            div_q <= 8'h00;
        else if (!pd_q)
            div_q <= div_q + 8'h01;
    end

    // Pin sampled once per machine cycle; a high-then-low pair is one count
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count_smp_q <= 1'b1;
        else if (tick)
            count_smp_q <= count_pin;
    end

    wire pin_fall = tick && count_smp_q && !count_pin;

    // Bus decode
    wire [7:0] idx = wb_adr_i[9:2];
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    wire wr = bus_req && wb_we_i && wb_sel_i[0] && !pd_q;
    wire [7:0] wbyte = wb_dat_i[7:0];
    wire wr_ctrl = wr && hit(idx, `ATS_IDX_CTRL);
    wire wr_clo = wr && hit(idx, `ATS_IDX_COUNT_LOW);
    wire wr_chi = wr && hit(idx, `ATS_IDX_COUNT_HIGH);
    wire wr_rlo = wr && hit(idx, `ATS_IDX_RELOAD_LOW);
    wire wr_rhi = wr && hit(idx, `ATS_IDX_RELOAD_HIGH);
    wire wr_ien = wr && hit(idx, `ATS_IDX_IRQ_ENABLE);
    wire wr_pwr = wr && hit(idx, `ATS_IDX_POWER);

    // Timer advance
    wire gate_on = ctrl_q[`ATS_CTRL_GATE];
    wire run_on = ctrl_q[`ATS_CTRL_RUN];
    wire enabled = run_on && (!gate_on || irq0_pin);
    wire src_pin = ctrl_q[`ATS_CTRL_SRC];
    wire inc = enabled && (src_pin ? pin_fall : tick);
    wire wrap = inc && (count_q == `ATS_COUNT_TOP);

    always_comb
    begin
        count_d = count_q;
        if (wrap)
            count_d = reload_q;
        else if (inc)
            count_d = count_q + 16'h0001;
        if (wr_clo)
            count_d[7:0] = wbyte;
        if (wr_chi)
            count_d[15:8] = wbyte;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count_q <= {`ATS_RESET_BYTE, `ATS_RESET_BYTE};
        else
            count_q <= count_d;
    end

    // Reload pair changes only on a software write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            reload_q <= {`ATS_RESET_BYTE, `ATS_RESET_BYTE};
        else
        begin
            if (wr_rlo)
                reload_q[7:0] <= wbyte;
            if (wr_rhi)
                reload_q[15:8] <= wbyte;
        end
    end

    // Interrupt pins, active low; edge is a high-to-low step
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_prev_q <= 2'h3;
        else
            irq_prev_q <= {irq1_pin, irq0_pin};
    end

    wire fall0 = irq_prev_q[0] && !irq0_pin;
    wire fall1 = irq_prev_q[1] && !irq1_pin;
    wire edge0 = ctrl_q[`ATS_CTRL_E0];
    wire edge1 = ctrl_q[`ATS_CTRL_E1];
    wire ack0 = irq_ack_i && (src_q == ATS_SRC_IRQ0);
    wire ackt = irq_ack_i && (src_q == ATS_SRC_TIMER);
    wire ack1 = irq_ack_i && (src_q == ATS_SRC_IRQ1);
    wire keep0 = wr_ctrl ? wbyte[`ATS_CTRL_P0] : ctrl_q[`ATS_CTRL_P0] && !ack0;
    wire keep1 = wr_ctrl ? wbyte[`ATS_CTRL_P1] : ctrl_q[`ATS_CTRL_P1] && !ack1;
    wire keept = wr_ctrl ? wbyte[`ATS_CTRL_OVF] : ctrl_q[`ATS_CTRL_OVF] && !ackt;

    // Set wins over any clear in the same cycle
    always_comb
    begin
        ctrl_d = wr_ctrl ? wbyte : ctrl_q;
        ctrl_d[`ATS_CTRL_OVF] = wrap || keept;
        ctrl_d[`ATS_CTRL_P0] = edge0 ? (fall0 || keep0) : !irq0_pin;
        ctrl_d[`ATS_CTRL_P1] = edge1 ? (fall1 || keep1) : !irq1_pin;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_q <= `ATS_RESET_BYTE;
        else
            ctrl_q <= ctrl_d;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ien_q <= `ATS_RESET_BYTE;
        else if (wr_ien)
            ien_q <= wbyte;
    end

    // Fixed single-level priority
    wire en_all = ien_q[`ATS_IEN_ALL];
    wire want0 = en_all && ien_q[`ATS_IEN_X0] && ctrl_q[`ATS_CTRL_P0];
    wire wantt = en_all && ien_q[`ATS_IEN_T] && ctrl_q[`ATS_CTRL_OVF];
    wire want1 = en_all && ien_q[`ATS_IEN_X1] && ctrl_q[`ATS_CTRL_P1];
    wire any_want = want0 || wantt || want1;
    wire ats_src_type src_d = want0 ? ATS_SRC_IRQ0 :
        wantt ? ATS_SRC_TIMER : want1 ? ATS_SRC_IRQ1 : ATS_SRC_NONE;
    wire [9:0] vec_d = want0 ? `ATS_VEC_X0 :
        wantt ? `ATS_VEC_T : want1 ? `ATS_VEC_X1 : vec_q;

    // The request stays one cycle behind the flags; the core acks once per entry
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            req_q <= 1'b0;
            src_q <= ATS_SRC_NONE;
            vec_q <= `ATS_VEC_RESET;
        end
        else
        begin
            req_q <= any_want;
            src_q <= src_d;
            vec_q <= vec_d;
        end
    end

    // Power-down latches until reset; idle ends on any enabled request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pd_q <= 1'b0;
            idle_q <= 1'b0;
        end
        else
        begin
            if (wr_pwr && wbyte[`ATS_PWR_PD])
                pd_q <= 1'b1;
            if (any_want)
                idle_q <= 1'b0;
            else if (wr_pwr && wbyte[`ATS_PWR_IDL])
                idle_q <= 1'b1;
        end
    end

    // Read mux; absent legacy slots and unmapped words read zero
    wire [7:0] rsel =
        hit(idx, `ATS_IDX_CTRL) ? ctrl_q :
        hit(idx, `ATS_IDX_COUNT_LOW) ? count_q[7:0] :
        hit(idx, `ATS_IDX_COUNT_HIGH) ? count_q[15:8] :
        hit(idx, `ATS_IDX_RELOAD_LOW) ? reload_q[7:0] :
        hit(idx, `ATS_IDX_RELOAD_HIGH) ? reload_q[15:8] :
        hit(idx, `ATS_IDX_IRQ_ENABLE) ? ien_q :
        hit(idx, `ATS_IDX_POWER) ? {6'h00, pd_q, idle_q} :
        `ATS_RESET_BYTE;

    // Every access is acked, even in power-down, so the bus never hangs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= bus_req;
            rdata_q <= {24'h000000, rsel};
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign irq_req_o = req_q;
    assign irq_vector_o = vec_q;
    assign irq_src_o = src_q;
    assign idle_o = idle_q;
    assign power_down_o = pd_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence wrap_s;
        inc && (count_q == `ATS_COUNT_TOP);
    endsequence

    sequence timer_ack_s;
        irq_ack_i && (src_q == ATS_SRC_TIMER) && !wrap && !wr_ctrl;
    endsequence

    bus_ack_pulse_a: assert property (ack_q |=> !ack_q)
        else $error("ack held longer than one cycle");

    pd_sticky_a: assert property (pd_q |=> pd_q && $stable(count_q))
        else $error("power-down left or counter moved");

    tick_period_a: assert property (tick |-> ##12 (tick || pd_q))
        else $error("machine cycle not twelve clocks");

    src_pin_a: assert property (src_pin && !pin_fall |-> !inc)
        else $error("counter mode advanced without a falling sample");

    run_hold_a: assert property (!run_on && !wr_clo && !wr_chi |=> $stable(count_q))
        else $error("count moved with run enable clear");

    reload_load_a: assert property (wrap_s and !wr_clo and !wr_chi
        |=> count_q == $past(reload_q) && ctrl_q[`ATS_CTRL_OVF])
        else $error("overflow did not reload and flag");

    reload_keep_a: assert property (wrap_s and !wr_rlo and !wr_rhi |=> $stable(reload_q))
        else $error("reload registers changed on overflow");

    ovf_clear_a: assert property (timer_ack_s |=> !ctrl_q[`ATS_CTRL_OVF])
        else $error("overflow flag kept after vectoring");

    gate_block_a: assert property (gate_on && !irq0_pin |-> !inc)
        else $error("gated timer advanced with first pin low");

    edge_set_a: assert property (edge0 && fall0 && !wr_ctrl
        |=> ctrl_q[`ATS_CTRL_P0] [*1] ##1 1)
        else $error("edge did not set pending");

    level_follow_a: assert property (!edge1 && !wr_ctrl
        |=> ctrl_q[`ATS_CTRL_P1] == !$past(irq1_pin))
        else $error("level pending does not follow pin");

    prio_order_a: assert property (want0 && wantt |=> src_q == ATS_SRC_IRQ0
        && vec_q == `ATS_VEC_X0 && req_q)
        else $error("first pin lost priority");

    vec_timer_a: assert property (wantt && !want0 |=> vec_q == `ATS_VEC_T)
        else $error("timer vector wrong");

    edge_ack_a: assert property (edge0 && ack0 && !fall0 && !wr_ctrl
        |=> !ctrl_q[`ATS_CTRL_P0])
        else $error("edge pending kept after vectoring");

    gone_read_a: assert property (bus_req && !wb_we_i && hit(idx, `ATS_IDX_GONE_PRIORITY)
        |=> wb_ack_o && wb_dat_o == 32'h00000000)
        else $error("absent register answered with data");
endmodule

// >>> tb/ats_timer_ctl_tb.sv
// Self-checking bench for the auto-reload timer and interrupt control block.
// Assumes ats_defs.svh on the include path and ats_pkg compiled before this file.
`include "ats_defs.svh"

module ats_timer_ctl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ats_pkg::*;

    logic clk_i, rst_i, cyc, stb, we, cnt_pin, pin_a, pin_b, irq_ack;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
    logic [31:0] dat_o;
    logic ack_o, req_o, idle_o, pd_o;
    logic [9:0] vec_o;
    ats_src_type src_o;
    logic [7:0] rd;
    int num_errors = 0;
    int n_tests = 0;

    ats_timer_ctl uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
        .count_input_pin_i(cnt_pin), .ext_irq_first_pin_i(pin_a),
        .ext_irq_second_pin_i(pin_b), .irq_ack_i(irq_ack), .irq_req_o(req_o),
        .irq_vector_o(vec_o), .irq_src_o(src_o), .idle_o(idle_o), .power_down_o(pd_o)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Holds the request until ack is sampled; read data is taken at that edge
    task bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h000000, d};
        sel <= 4'hF;
        for (i = 0; i < 20 && ack_o !== 1'b1; i++)
            @(posedge clk_i);
        if (ack_o !== 1'b1)
        begin
            num_errors++;
            stop_test();
        end
        rd = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00);
        check({24'h000000, rd}, {24'h000000, exp});
    endtask

    task wait_req(input ats_src_type s, input logic [9:0] v);
        int i;
        for (i = 0; i < 300 && req_o !== 1'b1; i++)
            @(posedge clk_i);
        if (req_o !== 1'b1)
        begin
            num_errors++;
            stop_test();
        end
        check(32'(src_o), 32'(s));
        check(32'(vec_o), 32'(v));
    endtask

    task vector_ack;
        @(posedge clk_i);
        irq_ack <= 1'b1;
        @(posedge clk_i);
        irq_ack <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    initial
    begin
        {cyc, stb, we, irq_ack} = 4'h0;
        {cnt_pin, pin_a, pin_b} = 3'b111;
        adr = 10'h000;
        sel = 4'h0;
        dat = 32'h00000000;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(32'(vec_o), 32'(`ATS_VEC_RESET));
        rd_chk(`ATS_IDX_CTRL, 8'h00);
        rd_chk(`ATS_IDX_RELOAD_HIGH, 8'h00);
        // Removed slots must neither store nor answer with data
        bus(`ATS_IDX_GONE_MODE, 1'b1, 8'hFF);
        bus(`ATS_IDX_GONE_PORT_TWO, 1'b1, 8'hFF);
        bus(`ATS_IDX_GONE_PRIORITY, 1'b1, 8'hFF);
        rd_chk(`ATS_IDX_GONE_MODE, 8'h00);
        rd_chk(`ATS_IDX_GONE_PORT_TWO, 8'h00);
        rd_chk(`ATS_IDX_GONE_PRIORITY, 8'h00);
        // Overflow three ticks away, reload one below the top
        bus(`ATS_IDX_RELOAD_HIGH, 1'b1, 8'hFF);
        bus(`ATS_IDX_RELOAD_LOW, 1'b1, 8'hFE);
        bus(`ATS_IDX_COUNT_HIGH, 1'b1, 8'hFF);
        bus(`ATS_IDX_COUNT_LOW, 1'b1, 8'hFD);
        bus(`ATS_IDX_IRQ_ENABLE, 1'b1, 8'h82);
        bus(`ATS_IDX_CTRL, 1'b1, 8'h10);
        wait_req(ATS_SRC_TIMER, `ATS_VEC_T);
        bus(`ATS_IDX_CTRL, 1'b1, 8'h20);
        rd_chk(`ATS_IDX_COUNT_LOW, 8'hFE);
        rd_chk(`ATS_IDX_COUNT_HIGH, 8'hFF);
        rd_chk(`ATS_IDX_RELOAD_LOW, 8'hFE);
        repeat (40) @(posedge clk_i);
        rd_chk(`ATS_IDX_COUNT_LOW, 8'hFE);
        rd_chk(`ATS_IDX_CTRL, 8'h20);
        vector_ack();
        rd_chk(`ATS_IDX_CTRL, 8'h00);
        check(32'(req_o), 32'h0);
        // Counter mode: three falls on the count pin, each held over several ticks
        bus(`ATS_IDX_COUNT_LOW, 1'b1, 8'h00);
        bus(`ATS_IDX_COUNT_HIGH, 1'b1, 8'h00);
        bus(`ATS_IDX_CTRL, 1'b1, 8'h50);
        repeat (3)
        begin
            cnt_pin <= 1'b0;
            repeat (40) @(posedge clk_i);
            cnt_pin <= 1'b1;
            repeat (40) @(posedge clk_i);
        end
        rd_chk(`ATS_IDX_COUNT_LOW, 8'h03);
        // Gated timer: no advance while the first pin is low
        bus(`ATS_IDX_IRQ_ENABLE, 1'b1, 8'h00);
        bus(`ATS_IDX_COUNT_LOW, 1'b1, 8'h00);
        pin_a <= 1'b0;
        bus(`ATS_IDX_CTRL, 1'b1, 8'h90);
        repeat (60) @(posedge clk_i);
        rd_chk(`ATS_IDX_COUNT_LOW, 8'h00);
        pin_a <= 1'b1;
        repeat (60) @(posedge clk_i);
        bus(`ATS_IDX_COUNT_LOW, 1'b0, 8'h00);
        check(32'(rd != 8'h00), 32'h1);
        // Edge mode on the first pin, cleared by vectoring
        bus(`ATS_IDX_CTRL, 1'b1, 8'h04);
        bus(`ATS_IDX_IRQ_ENABLE, 1'b1, 8'h81);
        pin_a <= 1'b0;
        wait_req(ATS_SRC_IRQ0, `ATS_VEC_X0);
        pin_a <= 1'b1;
        rd_chk(`ATS_IDX_CTRL, 8'h0C);
        vector_ack();
        rd_chk(`ATS_IDX_CTRL, 8'h04);
        // Level mode on the second pin: vectoring leaves it pending
        bus(`ATS_IDX_CTRL, 1'b1, 8'h00);
        bus(`ATS_IDX_IRQ_ENABLE, 1'b1, 8'h84);
        bus(`ATS_IDX_POWER, 1'b1, 8'h01);
        check(32'(idle_o), 32'h1);
        rd_chk(`ATS_IDX_POWER, 8'h01);
        pin_b <= 1'b0;
        wait_req(ATS_SRC_IRQ1, `ATS_VEC_X1);
        check(32'(idle_o), 32'h0);
        vector_ack();
        check(32'(req_o), 32'h1);
        pin_b <= 1'b1;
        repeat (8) @(posedge clk_i);
        check(32'(req_o), 32'h0);
        rd_chk(`ATS_IDX_CTRL, 8'h00);
        // Both pins edge-pending and overflow set while masked, then all enabled at once
        bus(`ATS_IDX_IRQ_ENABLE, 1'b1, 8'h00);
        bus(`ATS_IDX_CTRL, 1'b1, 8'h25);
        pin_a <= 1'b0;
        pin_b <= 1'b0;
        repeat (6) @(posedge clk_i);
        pin_a <= 1'b1;
        pin_b <= 1'b1;
        bus(`ATS_IDX_IRQ_ENABLE, 1'b1, 8'h87);
        wait_req(ATS_SRC_IRQ0, `ATS_VEC_X0);
        vector_ack();
        wait_req(ATS_SRC_TIMER, `ATS_VEC_T);
        vector_ack();
        wait_req(ATS_SRC_IRQ1, `ATS_VEC_X1);
        vector_ack();
        check(32'(req_o), 32'h0);
        // Power-down ignores writes and lasts until reset
        bus(`ATS_IDX_POWER, 1'b1, 8'h02);
        bus(`ATS_IDX_RELOAD_LOW, 1'b1, 8'h55);
        check(32'(pd_o), 32'h1);
        rd_chk(`ATS_IDX_POWER, 8'h02);
        rd_chk(`ATS_IDX_RELOAD_LOW, 8'hFE);
        repeat (30) @(posedge clk_i);
        check(32'(pd_o), 32'h1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(32'(pd_o), 32'h0);
        rd_chk(`ATS_IDX_RELOAD_LOW, 8'h00);
        stop_test();
    end
endmodule
